/* File: hdl/pseq_consts.svh */
// Register offsets, field positions, reset values and timing defaults of the power sequencer
`ifndef PSEQ_CONSTS_SVH
`define PSEQ_CONSTS_SVH

`define PSEQ_ADDR_W        8
`define PSEQ_OFF_CTRL      8'h00
`define PSEQ_OFF_ONMIN     8'h04
`define PSEQ_OFF_CMD       8'h08
`define PSEQ_OFF_STATUS    8'h0C

`define PSEQ_CTRL_TEMP_EN    0
`define PSEQ_CTRL_GREET_EN   1
`define PSEQ_CTRL_FIXED_BAUD 2
`define PSEQ_CTRL_ALARM_ARM  3
`define PSEQ_CTRL_W          4
`define PSEQ_CTRL_RST        4'h0

`define PSEQ_ONMIN_W       16
`define PSEQ_ONMIN_RST     16'h0064

`define PSEQ_CMD_OFF       0

`define PSEQ_ST_STATE_LSB  0
`define PSEQ_ST_IO_VOLTAGE_SELECT       3
`define PSEQ_ST_OK         4
`define PSEQ_ST_READY      5
`define PSEQ_ST_CAUSE_LSB  8

`define PSEQ_CAUSE_NONE    3'h0
`define PSEQ_CAUSE_GRACE   3'h1
`define PSEQ_CAUSE_HARD    3'h2
`define PSEQ_CAUSE_UVLO    3'h3
`define PSEQ_CAUSE_TEMP    3'h4

`define PSEQ_CLK_PERIOD_NS 40
`define PSEQ_RAMP_NS       1000
`define PSEQ_HOLD_NS       2000

`endif

/* File: hdl/pseq_pkg.sv */
// Types shared by the power sequencer files
package pseq_pkg;

  typedef enum logic [2:0] {
    ST_NOT_POWERED = 3'b000,
    ST_POWER_OFF   = 3'b001,
    ST_BOOTING     = 3'b010,
    ST_IN_RESET    = 3'b011,
    ST_OPERATING   = 3'b100,
    ST_SWITCH_OFF  = 3'b101
  } power_state_e;

  typedef enum logic [1:0] {
    PH_SAVE   = 2'b00,
    PH_DETACH = 2'b01,
    PH_DONE   = 2'b10
  } off_phase_e;

  typedef logic [2:0] shutdown_cause_t;

endpackage

/* File: hdl/low_pulse_qualifier.sv */
// Qualifies an active-low request level against a minimum low time in cycles
`timescale 1ns/1ps
module low_pulse_qualifier #(
  parameter int CNT_W = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             arm,
  input  wire logic             level_n,
  input  wire logic [CNT_W-1:0] min_cycles,
  output logic                  hit
);

  logic [CNT_W-1:0] count_ff;
  logic             fired_ff;

  generate
    if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
      $error("low_pulse_qualifier: CNT_W out of range");
    end
  endgenerate

  // Count low cycles; saturate so a long press cannot wrap and fire twice
  always_ff @(posedge clk) begin
    if (rst || !arm || level_n) begin
      count_ff <= '0;
    end else if (count_ff != {CNT_W{1'b1}}) begin
      count_ff <= count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // One hit per low pulse; pulses shorter than the minimum never fire
  always_ff @(posedge clk) begin
    if (rst || !arm || level_n) begin
      fired_ff <= 1'b0;
    end else if (hit) begin
      fired_ff <= 1'b1;
    end
  end

  assign hit = arm && !level_n && !fired_ff && (count_ff + {{(CNT_W-1){1'b0}}, 1'b1} >= min_cycles);

endmodule // low_pulse_qualifier

/* File: hdl/module_power_sequencer.sv */
// Power-state sequencer with APB control and status registers
`timescale 1ns/1ps
`include "pseq_consts.svh"

module module_power_sequencer #(
  parameter int PIN_COUNT = 8,
  parameter int RAMP_CYC  = (`PSEQ_RAMP_NS + `PSEQ_CLK_PERIOD_NS - 1) / `PSEQ_CLK_PERIOD_NS,
  parameter int HOLD_CYC  = (`PSEQ_HOLD_NS + `PSEQ_CLK_PERIOD_NS - 1) / `PSEQ_CLK_PERIOD_NS
) (
  input  wire logic                   CLK,
  input  wire logic                   SYS_RST,
  input  wire logic                   PSEL,
  input  wire logic                   PENABLE,
  input  wire logic                   PWRITE,
  input  wire logic [`PSEQ_ADDR_W-1:0] PADDR,
  input  wire logic [31:0]            PWDATA,
  output logic      [31:0]            PRDATA,
  output logic                        PREADY,
  output logic                        PSLVERR,
  input  wire logic                   MAIN_SUPPLY_VALID,
  input  wire logic                   POWER_ON_REQUEST_N,
  input  wire logic                   HARD_SHUTDOWN_N,
  input  wire logic                   IO_VOLTAGE_SELECT,
  input  wire logic                   RTC_ALARM,
  input  wire logic                   TEMP_DANGER,
  input  wire logic                   SETTINGS_SAVE_DONE,
  input  wire logic                   NETWORK_DETACH_DONE,
  output logic                        SETTINGS_SAVE_REQ,
  output logic                        NETWORK_DETACH_REQ,
  output logic                        IO_SUPPLY_EN,
  output logic                        IO_SUPPLY_3V0,
  output logic                        BACKUP_SUPPLY_EN,
  output logic                        POWER_ON_PULLUP_EN,
  output logic                        HARD_SHUTDOWN_PULLUP_EN,
  output logic                        CORE_RESET_N,
  output logic [PIN_COUNT-1:0]        GENERIC_DIGITAL_PINS_OE,
  output logic                        READY,
  output logic                        GREETING_PULSE,
  output logic [2:0]                  POWER_STATE
);

  localparam int CW = $clog2(PIN_COUNT + 1);
  localparam logic [CW-1:0] CFG_LAST = CW'(PIN_COUNT);
  localparam logic [15:0] RAMP_LOAD = 16'(RAMP_CYC - 1);
  localparam logic [15:0] HOLD_LOAD = 16'(HOLD_CYC - 1);

  generate
    if (PIN_COUNT < 1 || PIN_COUNT > 32) begin : g_bad_pins
      $error("module_power_sequencer: PIN_COUNT out of range");
    end
    if (RAMP_CYC < 1 || RAMP_CYC > 65536 || HOLD_CYC < 1 || HOLD_CYC > 65536) begin : g_bad_t
      $error("module_power_sequencer: timing count out of range");
    end
  endgenerate

  pseq_pkg::power_state_e    state_ff;
  pseq_pkg::power_state_e    nxt_state;
  pseq_pkg::off_phase_e      phase_ff;
  pseq_pkg::shutdown_cause_t cause_ff;

  logic [`PSEQ_CTRL_W-1:0]  ctrl_ff;
  logic [`PSEQ_ONMIN_W-1:0] onmin_ff;
  logic                     ok_ff;
  logic [15:0]              timer_ff;
  logic [CW-1:0]            cfg_ff;
  logic                     io_voltage_select_ff;
  logic                     io_en_ff;
  logic                     core_rst_n_ff;
  logic                     backup_ff;
  logic                     pullup_ff;
  logic                     ready_ff;
  logic                     greet_ff;
  logic [31:0]              prdata_ff;

  logic on_hit;
  logic alarm_hit;
  logic temp_trip;
  logic is_on;
  logic timer_done;
  logic wr_access;
  logic setup_rd;
  logic mapped;
  logic off_cmd;
  logic off_accept;
  logic cfg_done;

  // APB decode; zero wait states, registered read data
  assign wr_access = PSEL && PENABLE && PWRITE;
  assign setup_rd  = PSEL && !PENABLE && !PWRITE;
  assign mapped    = (PADDR == `PSEQ_OFF_CTRL) || (PADDR == `PSEQ_OFF_ONMIN) ||
                     (PADDR == `PSEQ_OFF_CMD)  || (PADDR == `PSEQ_OFF_STATUS);
  assign PREADY    = 1'b1;
  assign PSLVERR   = PSEL && PENABLE && !mapped;
  assign PRDATA    = prdata_ff;

  assign off_cmd    = wr_access && (PADDR == `PSEQ_OFF_CMD) && PWDATA[`PSEQ_CMD_OFF];
  // Commands outside normal operation are dropped, no reply is given
  assign off_accept = off_cmd && (state_ff == pseq_pkg::ST_OPERATING);

  assign is_on = (state_ff == pseq_pkg::ST_BOOTING)   || (state_ff == pseq_pkg::ST_IN_RESET) ||
                 (state_ff == pseq_pkg::ST_OPERATING) || (state_ff == pseq_pkg::ST_SWITCH_OFF);
  assign temp_trip  = ctrl_ff[`PSEQ_CTRL_TEMP_EN] && TEMP_DANGER;
  assign alarm_hit  = (state_ff == pseq_pkg::ST_POWER_OFF) && ctrl_ff[`PSEQ_CTRL_ALARM_ARM] &&
                      RTC_ALARM;
  assign timer_done = (timer_ff == 16'h0000);
  assign cfg_done   = (cfg_ff == CFG_LAST);

  low_pulse_qualifier #(
    .CNT_W (`PSEQ_ONMIN_W)
  ) u_on_qual (
    .clk        (CLK),
    .rst        (SYS_RST),
    .arm        (state_ff == pseq_pkg::ST_POWER_OFF),
    .level_n    (POWER_ON_REQUEST_N),
    .min_cycles (onmin_ff),
    .hit        (on_hit)
  );

  // Supply loss outranks everything, then hard shutdown, then temperature
  always_comb begin
    nxt_state = state_ff;
    if (!MAIN_SUPPLY_VALID) begin
      nxt_state = pseq_pkg::ST_NOT_POWERED;
    end else if (is_on && !HARD_SHUTDOWN_N) begin
      nxt_state = pseq_pkg::ST_POWER_OFF;
    end else if (is_on && temp_trip) begin
      nxt_state = pseq_pkg::ST_POWER_OFF;
    end else begin
      case (state_ff)
        pseq_pkg::ST_NOT_POWERED: begin
          nxt_state = pseq_pkg::ST_POWER_OFF;
        end
        pseq_pkg::ST_POWER_OFF: begin
          if (on_hit || alarm_hit) begin
            nxt_state = pseq_pkg::ST_BOOTING;
          end
        end
        pseq_pkg::ST_BOOTING: begin
          if (timer_done) begin
            nxt_state = pseq_pkg::ST_IN_RESET;
          end
        end
        pseq_pkg::ST_IN_RESET: begin
          if (timer_done) begin
            nxt_state = pseq_pkg::ST_OPERATING;
          end
        end
        pseq_pkg::ST_OPERATING: begin
          if (off_accept) begin
            nxt_state = pseq_pkg::ST_SWITCH_OFF;
          end
        end
        pseq_pkg::ST_SWITCH_OFF: begin
          if (phase_ff == pseq_pkg::PH_DONE) begin
            nxt_state = pseq_pkg::ST_POWER_OFF;
          end
        end
        default: begin
          nxt_state = pseq_pkg::ST_NOT_POWERED;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_ff <= pseq_pkg::ST_NOT_POWERED;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Phase timer, reloaded on entry to each timed state
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      timer_ff <= 16'h0000;
    end else if (nxt_state != state_ff) begin
      if (nxt_state == pseq_pkg::ST_BOOTING) begin
        timer_ff <= RAMP_LOAD;
      end else if (nxt_state == pseq_pkg::ST_IN_RESET) begin
        timer_ff <= HOLD_LOAD;
      end else begin
        timer_ff <= 16'h0000;
      end
    end else if (!timer_done) begin
      timer_ff <= timer_ff - 16'h0001;
    end
  end

  // Graceful switch-off: save settings, then detach, then finish
  always_ff @(posedge CLK) begin
    if (SYS_RST || state_ff != pseq_pkg::ST_SWITCH_OFF) begin
      phase_ff <= pseq_pkg::PH_SAVE;
    end else begin
      case (phase_ff)
        pseq_pkg::PH_SAVE: begin
          if (SETTINGS_SAVE_DONE) begin
            phase_ff <= pseq_pkg::PH_DETACH;
          end
        end
        pseq_pkg::PH_DETACH: begin
          if (NETWORK_DETACH_DONE) begin
            phase_ff <= pseq_pkg::PH_DONE;
          end
        end
        default: begin
          phase_ff <= pseq_pkg::PH_DONE;
        end
      endcase
    end
  end

  // Abrupt exits leave the phase machine mid-way and drop both requests, so a pending save or detach is never finished
  assign SETTINGS_SAVE_REQ  = (state_ff == pseq_pkg::ST_SWITCH_OFF) &&
                              (phase_ff == pseq_pkg::PH_SAVE);
  assign NETWORK_DETACH_REQ = (state_ff == pseq_pkg::ST_SWITCH_OFF) &&
                              (phase_ff == pseq_pkg::PH_DETACH);

  // Voltage select tracks the pin only while off; frozen from start-up on
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      io_voltage_select_ff <= 1'b0;
    end else if (!is_on && nxt_state != pseq_pkg::ST_BOOTING) begin
      io_voltage_select_ff <= IO_VOLTAGE_SELECT;
    end
  end

  // Interface supply, reset and pull-up outputs follow the next state so they line up with it; backup supply follows the main supply
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      io_en_ff      <= 1'b0;
      core_rst_n_ff <= 1'b0;
      backup_ff     <= 1'b0;
      pullup_ff     <= 1'b0;
    end else begin
      io_en_ff      <= (nxt_state == pseq_pkg::ST_BOOTING)   ||
                       (nxt_state == pseq_pkg::ST_IN_RESET)  ||
                       (nxt_state == pseq_pkg::ST_OPERATING) ||
                       (nxt_state == pseq_pkg::ST_SWITCH_OFF);
      core_rst_n_ff <= (nxt_state == pseq_pkg::ST_OPERATING) ||
                       (nxt_state == pseq_pkg::ST_SWITCH_OFF);
      backup_ff     <= MAIN_SUPPLY_VALID;
      pullup_ff     <= (nxt_state != pseq_pkg::ST_NOT_POWERED);
    end
  end

  assign IO_SUPPLY_EN            = io_en_ff;
  assign IO_SUPPLY_3V0           = io_voltage_select_ff;
  assign CORE_RESET_N            = core_rst_n_ff;
  assign BACKUP_SUPPLY_EN        = backup_ff;
  assign POWER_ON_PULLUP_EN      = pullup_ff;
  assign HARD_SHUTDOWN_PULLUP_EN = pullup_ff;
  assign POWER_STATE             = state_ff;

  // Pin release sequencer: one pin per cycle once reset is released
  always_ff @(posedge CLK) begin
    if (SYS_RST || !(nxt_state == pseq_pkg::ST_OPERATING ||
                     nxt_state == pseq_pkg::ST_SWITCH_OFF)) begin
      cfg_ff <= '0;
    end else if (!cfg_done) begin
      cfg_ff <= cfg_ff + CW'(1);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
      logic oe_ff;
      always_ff @(posedge CLK) begin
        if (SYS_RST) begin
          oe_ff <= 1'b0;
        end else begin
          // Drop with the leaving edge so no pin outlives the interface supply
          oe_ff <= (cfg_ff > CW'(gi)) && io_en_ff &&
                   (nxt_state == pseq_pkg::ST_OPERATING ||
                    nxt_state == pseq_pkg::ST_SWITCH_OFF);
        end
      end
      assign GENERIC_DIGITAL_PINS_OE[gi] = oe_ff;
    end
  endgenerate

  // Ready and greeting; without fixed baud the greeting cannot be timed, so it is held back
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ready_ff <= 1'b0;
      greet_ff <= 1'b0;
    end else begin
      ready_ff <= (state_ff == pseq_pkg::ST_OPERATING) && cfg_done;
      greet_ff <= (state_ff == pseq_pkg::ST_OPERATING) && cfg_done && !ready_ff &&
                  ctrl_ff[`PSEQ_CTRL_GREET_EN] && ctrl_ff[`PSEQ_CTRL_FIXED_BAUD];
    end
  end

  assign READY          = ready_ff;
  assign GREETING_PULSE = greet_ff;

  // Control register; alarm arm is cleared by hardware when the alarm fires
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl_ff <= `PSEQ_CTRL_RST;
    end else if (wr_access && PADDR == `PSEQ_OFF_CTRL) begin
      ctrl_ff <= PWDATA[`PSEQ_CTRL_W-1:0];
    end else if (alarm_hit) begin
      ctrl_ff[`PSEQ_CTRL_ALARM_ARM] <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      onmin_ff <= `PSEQ_ONMIN_RST;
    end else if (wr_access && PADDR == `PSEQ_OFF_ONMIN) begin
      onmin_ff <= PWDATA[`PSEQ_ONMIN_W-1:0];
    end
  end

  // OK reply flag: write one to clear, a new accept in the same cycle wins
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ok_ff <= 1'b0;
    end else if (off_accept) begin
      ok_ff <= 1'b1;
    end else if (wr_access && PADDR == `PSEQ_OFF_STATUS && PWDATA[`PSEQ_ST_OK]) begin
      ok_ff <= 1'b0;
    end
  end

  // Last shutdown cause, kept until the next one
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cause_ff <= `PSEQ_CAUSE_NONE;
    end else if (is_on && !MAIN_SUPPLY_VALID) begin
      cause_ff <= `PSEQ_CAUSE_UVLO;
    end else if (is_on && !HARD_SHUTDOWN_N) begin
      cause_ff <= `PSEQ_CAUSE_HARD;
    end else if (is_on && temp_trip) begin
      cause_ff <= `PSEQ_CAUSE_TEMP;
    end else if (state_ff == pseq_pkg::ST_SWITCH_OFF && nxt_state == pseq_pkg::ST_POWER_OFF) begin
      cause_ff <= `PSEQ_CAUSE_GRACE;
    end
  end

  // Read data captured in the setup cycle; unmapped and command reads give zero
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      prdata_ff <= 32'h00000000;
    end else if (setup_rd) begin
      prdata_ff <= 32'h00000000;
      case (PADDR)
        `PSEQ_OFF_CTRL: begin
          prdata_ff[`PSEQ_CTRL_W-1:0] <= ctrl_ff;
        end
        `PSEQ_OFF_ONMIN: begin
          prdata_ff[`PSEQ_ONMIN_W-1:0] <= onmin_ff;
        end
        `PSEQ_OFF_STATUS: begin
          prdata_ff[`PSEQ_ST_STATE_LSB +: 3] <= state_ff;
          prdata_ff[`PSEQ_ST_IO_VOLTAGE_SELECT]           <= io_voltage_select_ff;
          prdata_ff[`PSEQ_ST_OK]             <= ok_ff;
          prdata_ff[`PSEQ_ST_READY]          <= ready_ff;
          prdata_ff[`PSEQ_ST_CAUSE_LSB +: 3] <= cause_ff;
        end
        default: begin
          prdata_ff <= 32'h00000000;
        end
      endcase
    end
  end

endmodule // module_power_sequencer

/* File: tb/pseq_properties.sv */
// Concurrent checks on the power sequencer top-level ports
`timescale 1ns/1ps
module pseq_properties #(
  parameter int PIN_COUNT = 8
) (
  input wire logic                 CLK,
  input wire logic                 SYS_RST,
  input wire logic                 PSEL,
  input wire logic                 PENABLE,
  input wire logic                 PWRITE,
  input wire logic [7:0]           PADDR,
  input wire logic [31:0]          PWDATA,
  input wire logic                 MAIN_SUPPLY_VALID,
  input wire logic                 HARD_SHUTDOWN_N,
  input wire logic                 TEMP_DANGER,
  input wire logic                 SETTINGS_SAVE_REQ,
  input wire logic                 IO_SUPPLY_EN,
  input wire logic                 IO_SUPPLY_3V0,
  input wire logic                 BACKUP_SUPPLY_EN,
  input wire logic                 CORE_RESET_N,
  input wire logic [PIN_COUNT-1:0] GENERIC_DIGITAL_PINS_OE,
  input wire logic                 READY,
  input wire logic [2:0]           POWER_STATE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  chk_supply_off_state:
    assert property (POWER_STATE inside {3'h0, 3'h1} |-> !IO_SUPPLY_EN)
    else $error("interface supply on while switched off");
  chk_notpow_exit:
    assert property ($past(POWER_STATE) == 3'h0 |-> POWER_STATE inside {3'h0, 3'h1})
    else $error("left not-powered to a state other than power-off");
  chk_core_after_supply:
    assert property ($rose(CORE_RESET_N) |-> IO_SUPPLY_EN && $past(IO_SUPPLY_EN, 2))
    else $error("core reset released without supply on first");
  chk_pins_in_reset:
    assert property ((!CORE_RESET_N || !IO_SUPPLY_EN) |-> GENERIC_DIGITAL_PINS_OE == '0)
    else $error("pin driven while in reset or unpowered");
  chk_backup_follow:
    assert property (!$past(SYS_RST) |-> BACKUP_SUPPLY_EN == $past(MAIN_SUPPLY_VALID))
    else $error("backup supply does not follow main supply");
  chk_hard_abort:
    assert property ((!HARD_SHUTDOWN_N && MAIN_SUPPLY_VALID && POWER_STATE inside {[3'h2:3'h5]})
      |=> POWER_STATE == 3'h1 && !IO_SUPPLY_EN && !SETTINGS_SAVE_REQ)
    else $error("hard shutdown not taken at once");
  chk_supply_loss:
    assert property (!MAIN_SUPPLY_VALID |=> POWER_STATE == 3'h0 && !IO_SUPPLY_EN && !CORE_RESET_N)
    else $error("supply loss did not drop to not-powered");
  chk_io_voltage_select_frozen:
    assert property (IO_SUPPLY_EN && $past(IO_SUPPLY_EN) |-> $stable(IO_SUPPLY_3V0))
    else $error("interface level changed while switched on");
  chk_off_command:
    assert property ((PSEL && PENABLE && PWRITE && PADDR == 8'h08 && PWDATA[0]
      && POWER_STATE == 3'h4 && MAIN_SUPPLY_VALID && HARD_SHUTDOWN_N && !TEMP_DANGER)
      |=> POWER_STATE == 3'h5 && SETTINGS_SAVE_REQ)
    else $error("off command did not start the save phase");
  chk_ready_after:
    assert property ($rose(CORE_RESET_N) |-> ##[1:40] READY)
    else $error("ready not reached after reset release");

  cover property ($past(POWER_STATE) == 3'h5 && POWER_STATE == 3'h1);
  cover property ($rose(READY));
  cover property (!HARD_SHUTDOWN_N && POWER_STATE == 3'h3);
endmodule // pseq_properties

bind module_power_sequencer pseq_properties #(.PIN_COUNT(PIN_COUNT)) pseq_properties_inst (
  .CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .MAIN_SUPPLY_VALID(MAIN_SUPPLY_VALID),
  .HARD_SHUTDOWN_N(HARD_SHUTDOWN_N), .TEMP_DANGER(TEMP_DANGER),
  .SETTINGS_SAVE_REQ(SETTINGS_SAVE_REQ), .IO_SUPPLY_EN(IO_SUPPLY_EN),
  .IO_SUPPLY_3V0(IO_SUPPLY_3V0), .BACKUP_SUPPLY_EN(BACKUP_SUPPLY_EN),
  .CORE_RESET_N(CORE_RESET_N), .GENERIC_DIGITAL_PINS_OE(GENERIC_DIGITAL_PINS_OE),
  .READY(READY), .POWER_STATE(POWER_STATE));

/* File: tb/host_partner.sv */
// Host-side model answering the save and detach phases of a graceful off
`timescale 1ns/1ps
module host_partner (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic slow,
  input  wire logic save_req,
  input  wire logic detach_req,
  output logic      save_done,
  output logic      detach_done
);
  logic [3:0] wait_ff;

  // One-cycle done pulse; slow mode stretches the phase so aborts can land mid-way
  always_ff @(posedge clk) begin
    save_done   <= 1'b0;
    detach_done <= 1'b0;
    if (rst) begin
      wait_ff <= 4'h0;
    end else if ((save_req && !save_done) || (detach_req && !detach_done)) begin
      if (wait_ff == (slow ? 4'h6 : 4'h1)) begin
        wait_ff     <= 4'h0;
        save_done   <= save_req;
        detach_done <= detach_req && !save_req;
      end else begin
        wait_ff <= wait_ff + 4'h1;
      end
    end else begin
      wait_ff <= 4'h0;
    end
  end
endmodule // host_partner

/* File: tb/tb_module_power_sequencer.sv */
// Self-checking bench for the power sequencer
`timescale 1ns/1ps
`include "pseq_consts.svh"
module tb_module_power_sequencer;
  localparam int RAMP = 3;
  localparam int HOLD = 4;
  localparam int PINS = 8;
  typedef struct {logic alarm; logic io_voltage_select; logic [3:0] ctrl; logic greet; logic slow;} row_s;
  row_s rows[4] = '{'{1'b0, 1'b0, 4'h0, 1'b0, 1'b0}, '{1'b1, 1'b1, 4'hE, 1'b1, 1'b1},
                    '{1'b0, 1'b1, 4'h2, 1'b0, 1'b0}, '{1'b1, 1'b0, 4'hC, 1'b0, 1'b1}};
  logic        clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, supply_ok = 1'b1, pon_n = 1'b1, hard_n = 1'b1, io_voltage_select = 1'b0;
  logic        alarm = 1'b0, temp_bad = 1'b0, slow = 1'b0, e;
  logic        save_done, detach_done, save_req, detach_req, io_en, io_3v0, bkp_en;
  logic        pu_on, pu_hard, core_rst_n, ready, greet;
  logic [7:0]  oe;
  logic [2:0]  state;
  int          err_total = 0, n_tests = 0, cyc = 0, n;

  module_power_sequencer #(.RAMP_CYC(RAMP), .HOLD_CYC(HOLD)) module_power_sequencer_inst (
    .CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .MAIN_SUPPLY_VALID(supply_ok), .POWER_ON_REQUEST_N(pon_n), .HARD_SHUTDOWN_N(hard_n),
    .IO_VOLTAGE_SELECT(io_voltage_select), .RTC_ALARM(alarm), .TEMP_DANGER(temp_bad),
    .SETTINGS_SAVE_DONE(save_done), .NETWORK_DETACH_DONE(detach_done),
    .SETTINGS_SAVE_REQ(save_req), .NETWORK_DETACH_REQ(detach_req), .IO_SUPPLY_EN(io_en),
    .IO_SUPPLY_3V0(io_3v0), .BACKUP_SUPPLY_EN(bkp_en), .POWER_ON_PULLUP_EN(pu_on),
    .HARD_SHUTDOWN_PULLUP_EN(pu_hard), .CORE_RESET_N(core_rst_n),
    .GENERIC_DIGITAL_PINS_OE(oe), .READY(ready), .GREETING_PULSE(greet), .POWER_STATE(state));
  host_partner host_partner_inst (.clk(clk), .rst(sys_rst), .slow(slow), .save_req(save_req),
    .detach_req(detach_req), .save_done(save_done), .detach_done(detach_done));

  always #20 clk = ~clk;

  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Generous ceiling: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      final_report();
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wait_state(input logic [2:0] s);
    n = 0;
    do begin @(negedge clk); n++; end while (state !== s && n < 200);
    check(state, s, "state wait");
  endtask

  task wait_ready;
    n = 0;
    do begin @(negedge clk); n++; end while (ready !== 1'b1 && n < 50);
  endtask

  task press(input int len);
    @(posedge clk) pon_n <= 1'b0;
    repeat (len) @(posedge clk);
    pon_n <= 1'b1;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b1, `PSEQ_OFF_ONMIN, 32'h5);
    for (int i = 0; i < 4; i++) begin
      io_voltage_select <= rows[i].io_voltage_select;
      apb(1'b1, `PSEQ_OFF_CTRL, {28'h0, rows[i].ctrl});
      check({pu_on, pu_hard}, 2'h3, "pull-ups idle");
      if (rows[i].alarm) begin
        @(posedge clk) alarm <= 1'b1;
        @(posedge clk) alarm <= 1'b0;
      end else press(5);
      wait_state(3'h2);
      check({io_en, core_rst_n}, 2'h2, "supply before reset release");
      @(posedge clk) io_voltage_select <= ~rows[i].io_voltage_select;
      wait_state(3'h4);
      check(n, RAMP + HOLD, "boot length");
      check(io_3v0, rows[i].io_voltage_select, "interface level");
      wait_ready();
      check(n, PINS, "ready delay");
      check(oe, 8'hFF, "pins configured");
      check(greet, rows[i].greet, "greeting");
      slow <= rows[i].slow;
      apb(1'b1, `PSEQ_OFF_CMD, 32'h1);
      wait_state(3'h1);
      check({io_en, oe, bkp_en}, 10'h001, "off outputs");
      apb(1'b0, `PSEQ_OFF_STATUS, 32'h0);
      check({q[10:8], q[4]}, {`PSEQ_CAUSE_GRACE, 1'b1}, "off cause");
      $display("row %0d done", i);
    end
    // Short press, and an alarm whose arm was cleared by the last firing
    press(4);
    @(posedge clk) alarm <= 1'b1;
    @(posedge clk) alarm <= 1'b0;
    apb(1'b1, `PSEQ_OFF_CMD, 32'h1);
    repeat (6) @(negedge clk);
    check(state, 3'h1, "ignored requests");
    $display("ignored requests done");
    // Hard shutdown while the core is still held in reset
    press(5);
    wait_state(3'h3);
    @(posedge clk) hard_n <= 1'b0;
    @(posedge clk) hard_n <= 1'b1;
    @(negedge clk);
    check({state, io_en, save_req}, 5'h04, "hard shutdown");
    apb(1'b0, `PSEQ_OFF_STATUS, 32'h0);
    check(q[10:8], `PSEQ_CAUSE_HARD, "hard cause");
    $display("hard shutdown done");
    // Temperature shutdown once operating
    apb(1'b1, `PSEQ_OFF_CTRL, 32'h1);
    press(5);
    wait_state(3'h4);
    wait_ready();
    @(posedge clk) temp_bad <= 1'b1;
    @(posedge clk) temp_bad <= 1'b0;
    @(negedge clk);
    check({state, io_en}, 4'h2, "temperature shutdown");
    apb(1'b0, `PSEQ_OFF_STATUS, 32'h0);
    check(q[10:8], `PSEQ_CAUSE_TEMP, "temperature cause");
    $display("temperature done");
    // Supply lost mid-way through a slow graceful off
    apb(1'b1, `PSEQ_OFF_CTRL, 32'h0);
    press(5);
    wait_state(3'h4);
    wait_ready();
    slow <= 1'b1;
    apb(1'b1, `PSEQ_OFF_CMD, 32'h1);
    @(posedge clk) supply_ok <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check({state, io_en, bkp_en}, 5'h00, "supply loss");
    press(5);
    @(posedge clk) supply_ok <= 1'b1;
    repeat (5) @(negedge clk);
    check({state, io_en}, 4'h2, "supply restored");
    $display("supply loss done");
    // Unmapped address answers with an error and zero data
    apb(1'b0, 8'h10, 32'h0);
    check({e, q}, {1'b1, 32'h0}, "unmapped read");
    // Mid-run reset brings registers back to their reset values
    @(posedge clk) sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    check({state, pready}, 4'h1, "reset state");
    apb(1'b0, `PSEQ_OFF_ONMIN, 32'h0);
    check(q, {16'h0, `PSEQ_ONMIN_RST}, "onmin reset");
    apb(1'b0, `PSEQ_OFF_CTRL, 32'h0);
    check(q, 32'h0, "ctrl reset");
    $display("reset done");
    final_report();
  end
endmodule // tb_module_power_sequencer
